// *** bench/smka_annunciator_monitor.sv ***
// Purpose: Port-level checks of the annunciator's lamps, piezo and control requests.
// Assumes: Short flash and debounce counts, as the bench sets them.
// Notes:   Bound into every smka_annunciator; sees ports only.
`timescale 1ns/1ps
module smka_annunciator_monitor #(
  parameter int FLASH_HALF_CYC = 8,
  parameter int DEBOUNCE_CYC   = 4
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Switch and panel inputs
  input wire logic [15:0] toggle_on_pin,
  input wire logic [15:0] toggle_off_pin,
  input wire logic [7:0]  config_switch_pin,
  input wire logic        ack_button_pin,
  input wire logic        link_alive,
  input wire logic        expander_present,
  input wire logic        upper_points_unused,
  input wire logic        panel_smoke_mode,
  // Outputs under watch
  input wire logic [15:0] on_open_control_output,
  input wire logic [15:0] off_closed_control_output,
  input wire logic [15:0] group_manual,
  input wire logic [15:0] led_green,
  input wire logic [15:0] led_yellow,
  input wire logic [15:0] led_amber,
  input wire logic        piezo
);
  // Slack covers the input synchronisers before a flash or silence shows.
  localparam int FL2 = 2 * FLASH_HALF_CYC + 8;
  localparam int DBW = DEBOUNCE_CYC + 12;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_link_amber: assert property ($fell(link_alive) |-> ##[1:FL2] led_amber == '1)
    else $error("amber lamps idle on link loss");
  a_link_piezo: assert property ($fell(link_alive) |-> ##[1:8] piezo)
    else $error("piezo silent on link loss");
  a_exp_yellow: assert property ($rose(!expander_present && !upper_points_unused) |-> ##[1:FL2] led_yellow == '1)
    else $error("yellow lamps idle on expander trouble");
  a_factory_green: assert property ($rose(config_switch_pin[5:0] == 6'h00) |-> ##[1:FL2] led_green == '1)
    else $error("green lamps idle on default switches");
  a_ack_silence: assert property ($rose(ack_button_pin) |-> ##[1:DBW] !piezo)
    else $error("piezo not silenced");
  a_manual_excl: assert property ((group_manual & on_open_control_output & off_closed_control_output) == '0)
    else $error("both requests active in manual group");
  a_debounce_hold: assert property ($changed({toggle_on_pin, toggle_off_pin}) |=> $stable(group_manual)[*3])
    else $error("switch change taken too soon");
  a_amber_quiet: assert property ((link_alive && panel_smoke_mode == config_switch_pin[5])[*8] ##1
    (link_alive && panel_smoke_mode == config_switch_pin[5])[*8] |-> led_amber == '0)
    else $error("amber lit without trouble");
  c_link: cover property (!link_alive && led_amber == '1);
  c_ack: cover property ($fell(piezo));
  c_manual: cover property (group_manual == 16'hffff);
endmodule : smka_annunciator_monitor
bind smka_annunciator smka_annunciator_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_mon (.*);

// *** bench/smka_panel_model.sv ***
// Purpose: Behavioural panel on the far side of the annunciator.
// Assumes: Equipment settles to its request one cycle later.
// Notes:   Event requests freeze for a group under manual control.
`timescale 1ns/1ps
module smka_panel_model (
  // Clock
  input  wire logic        aclk,
  // Event requests from the sequence
  input  wire logic [15:0] ev_on,
  input  wire logic [15:0] ev_off,
  // Requests from the annunciator
  input  wire logic [15:0] on_ctl,
  input  wire logic [15:0] off_ctl,
  input  wire logic [15:0] manual,
  // Levels back to the annunciator
  output logic      [15:0] pev_on,
  output logic      [15:0] pev_off,
  output logic      [15:0] ver_on,
  output logic      [15:0] ver_off
);
  // AUTO groups follow event programming; manual groups keep the last request.
  always @(posedge aclk) begin
    pev_on  <= (ev_on & ~manual) | (pev_on & manual);
    pev_off <= (ev_off & ~manual) | (pev_off & manual);
    ver_on  <= on_ctl;
    ver_off <= off_ctl;
  end
endmodule : smka_panel_model

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the annunciator.
// Assumes: Flash half period 8 and debounce 4 cycles.
// Notes:   Registers are reached by AXI4-Lite tasks.
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, ack_button_pin, piezo, link_alive, expander_present;
  logic        upper_points_unused, panel_smoke_mode;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, ty [16];
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  config_switch_pin;
  logic [15:0] toggle_on_pin, toggle_off_pin, ev_on, ev_off, panel_event_on_open, panel_event_off_closed;
  logic [15:0] on_open_verify_input, off_closed_verify_input, on_open_control_output, off_closed_control_output;
  logic [15:0] group_manual, led_green, led_yellow, led_amber, xo, xf, xg, xy;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  smka_annunciator #(.FLASH_HALF_CYC(8), .DEBOUNCE_CYC(4)) uut (.*);
  smka_panel_model u_panel (.aclk(aclk), .ev_on(ev_on), .ev_off(ev_off), .on_ctl(on_open_control_output),
    .off_ctl(off_closed_control_output), .manual(group_manual), .pev_on(panel_event_on_open),
    .pev_off(panel_event_off_closed), .ver_on(on_open_verify_input), .ver_off(off_closed_verify_input));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Watch a lamp bank: a rapid flash shows both all-lit and all-dark.
  task automatic flash(input int s, input string m);
    logic        hi, lo;
    logic [15:0] v;
    hi = 1'b0;
    lo = 1'b0;
    repeat (72) begin
      @(posedge aclk);
      v = s == 0 ? led_amber : s == 1 ? led_yellow : led_green;
      hi |= v === '1;
      lo |= v === '0;
    end
    chk({hi, lo}, 2'b11, m);
  endtask : flash
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Cut a hang short.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ack_button_pin, aresetn} = '0;
    {awaddr, araddr, wdata, toggle_on_pin, toggle_off_pin} = '0;
    wstrb = 4'hf;
    config_switch_pin = 8'h20;
    {link_alive, expander_present, upper_points_unused, panel_smoke_mode} = 4'b1101;
    ev_on = 16'h5555;
    ev_off = 16'h0aaa;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wr(6'h04, 32'h8765_4321);
    wr(6'h08, 32'h0000_0009);
    rd(6'h04);
    chk({r, d}, {2'h0, 32'h8765_4321}, "type readback");
    rd(6'h3c);
    chk({r, d}, {2'h2, 32'h0}, "unmapped read");
    wr(6'h0c, 32'h1);
    chk(r, 2'h2, "status write");
    for (int k = 0; k < 16; k++) ty[k] = k < 9 ? 4'(k + 1) : 4'h0;
    for (int dd = 0; dd < 2; dd++) begin
      wr(6'h00, dd);
      rd(6'h00);
      chk(d, dd, "ctrl readback");
      // Positions: 0 ON, 1 OFF, 2 AUTO with both contacts closed.
      for (int p = 0; p < 3; p++) begin
        toggle_on_pin  <= p != 1 ? 16'hffff : 16'h0;
        toggle_off_pin <= p != 0 ? 16'hffff : 16'h0;
        repeat (24) @(posedge aclk);
        for (int k = 0; k < 16; k++) begin
          xo[k] = ty[k] >= 4 && ty[k] <= 9 && (p == 0 || p == 2 && ev_on[k]);
          xf[k] = ty[k] >= 1 && ty[k] <= 9 && (ty[k] <= 3 || ty[k] >= 7) && (p == 1 || p == 2 && ev_off[k]);
          xg[k] = ty[k] == 0 ? 1'b0 : ty[k] % 3 == 1 ? !xf[k] : xo[k];
          xy[k] = ty[k] == 0 ? 1'b0 : ty[k] % 3 == 2 ? !xo[k] : xo[k];
        end
        chk({on_open_control_output, off_closed_control_output}, {xo, xf}, "control map");
        chk({led_green, led_yellow, led_amber}, {xg, xy, 16'h0}, "lamps");
        chk(group_manual, p == 2 ? 16'h0 : 16'hffff, "manual");
        rd(6'h10);
        chk(d, {toggle_off_pin, toggle_on_pin}, "switch image");
      end
    end
    link_alive <= 1'b0;
    flash(0, "link amber");
    chk(piezo, 1'b1, "link piezo");
    ack_button_pin <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(piezo, 1'b0, "ack silence");
    ack_button_pin <= 1'b0;
    link_alive <= 1'b1;
    repeat (40) @(posedge aclk);
    expander_present <= 1'b0;
    flash(1, "expander yellow");
    chk(piezo, 1'b1, "expander piezo");
    expander_present <= 1'b1;
    config_switch_pin <= 8'h00;
    flash(2, "factory green");
    config_switch_pin <= 8'h20;
    panel_smoke_mode <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(6'h0c);
    chk(d[3], 1'b1, "mode trouble");
    flash(0, "mode amber");
    print_verdict();
  end
endmodule : tb_top

// *** core/smka_annunciator.sv ***
// Purpose: Switch to control mapping, indicator drive and module trouble annunciation.
// Assumes: Panel-side status arrives as levels on pins; software sets group types over AXI4-Lite.
// Notes:   One write and one read at a time; every output is a flip-flop.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module smka_annunciator #(
  parameter int unsigned FLASH_HALF_CYC = smka_pkg::FLASH_HALF_CYC,
  parameter int unsigned DEBOUNCE_CYC   = smka_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // AXI4-Lite write address and data
  input  wire logic [smka_pkg::ADDR_W-1:0]      awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  // AXI4-Lite write response
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  // AXI4-Lite read
  input  wire logic [smka_pkg::ADDR_W-1:0]      araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [31:0]                           rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready,
  // Front panel switches
  input  wire logic [smka_pkg::NGRP-1:0]        toggle_on_pin,
  input  wire logic [smka_pkg::NGRP-1:0]        toggle_off_pin,
  input  wire logic [smka_pkg::NCFG-1:0]        config_switch_pin,
  input  wire logic                             ack_button_pin,
  // Panel side status levels
  input  wire logic                             link_alive,
  input  wire logic                             expander_present,
  input  wire logic                             upper_points_unused,
  input  wire logic                             panel_smoke_mode,
  input  wire logic [smka_pkg::NGRP-1:0]        panel_event_on_open,
  input  wire logic [smka_pkg::NGRP-1:0]        panel_event_off_closed,
  input  wire logic [smka_pkg::NGRP-1:0]        on_open_verify_input,
  input  wire logic [smka_pkg::NGRP-1:0]        off_closed_verify_input,
  // Control requests toward the panel
  output logic [smka_pkg::NGRP-1:0]             on_open_control_output,
  output logic [smka_pkg::NGRP-1:0]             off_closed_control_output,
  output logic [smka_pkg::NGRP-1:0]             group_manual,
  // Indicators
  output logic [smka_pkg::NGRP-1:0]             led_green,
  output logic [smka_pkg::NGRP-1:0]             led_yellow,
  output logic [smka_pkg::NGRP-1:0]             led_amber,
  output logic                                  piezo
);

  localparam int unsigned NG    = smka_pkg::NGRP;
  localparam int unsigned SW_W  = 2 * NG + smka_pkg::NCFG + 1;  // Debounced switch bundle.
  localparam int unsigned PN_W  = 4 * NG + 4;                   // Synchronised panel bundle.

  // ----------------------------------------------------------------------
  // Mapping functions
  // ----------------------------------------------------------------------

  // Returns {on_open, off_closed} for one group. Dedicated and non-dedicated
  // systems share this map, so the dedicated bit never enters it.
  function automatic logic [1:0] ctl_map(input logic [3:0] typ, input smka_pkg::smka_pos_e pos,
                                         input logic ev_on, input logic ev_off);
    logic [1:0] r;
    r = 2'h0;
    if (typ >= 4'h1 && typ <= 4'h3) begin
      if (pos == smka_pkg::POS_ON) r = 2'h0;
      else if (pos == smka_pkg::POS_OFF) r = 2'h1;
      else r = {1'b0, ev_off};
    end else if (typ >= 4'h4 && typ <= 4'h6) begin
      if (pos == smka_pkg::POS_ON) r = 2'h2;
      else if (pos == smka_pkg::POS_OFF) r = 2'h0;
      else r = {ev_on, 1'b0};
    end else if (typ >= 4'h7 && typ <= 4'h9) begin
      if (pos == smka_pkg::POS_ON) r = 2'h2;
      else if (pos == smka_pkg::POS_OFF) r = 2'h1;
      else r = {ev_on, ev_off};
    end
    return r;
  endfunction : ctl_map

  // Returns {green, yellow} from the verification inputs for one group.
  function automatic logic [1:0] led_map(input logic [3:0] typ, input logic v_on, input logic v_off);
    logic [1:0] r;
    r = 2'h0;
    case (typ)
      4'h1, 4'h4, 4'h7: r = {~v_off, v_on};
      4'h2, 4'h5, 4'h8: r = {v_on, ~v_on};
      4'h3, 4'h6, 4'h9: r = {v_on, v_on};
      default:          r = 2'h0;
    endcase
    return r;
  endfunction : led_map

  // Merges a write into a register under the byte strobes.
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = val[8*b +: 8];
    end
    return r;
  endfunction : apply_strb

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [SW_W-1:0] sw_meta_q, sw_sync_q;  // Two-stage sync of the switches.
  logic [PN_W-1:0] pn_meta_q, pn_sync_q;  // Two-stage sync of the panel levels.

  wire [SW_W-1:0] sw_raw = {ack_button_pin, config_switch_pin, toggle_off_pin, toggle_on_pin};
  wire [PN_W-1:0] pn_raw = {panel_smoke_mode, upper_points_unused, expander_present, link_alive,
                            off_closed_verify_input, on_open_verify_input,
                            panel_event_off_closed, panel_event_on_open};

  // Only the second stage is read by any logic.
  always_ff @(posedge aclk) begin
    sw_meta_q <= sw_raw;
    sw_sync_q <= sw_meta_q;
    pn_meta_q <= pn_raw;
    pn_sync_q <= pn_meta_q;
  end

  wire [NG-1:0] ev_on_s  = pn_sync_q[0 +: NG];
  wire [NG-1:0] ev_off_s = pn_sync_q[NG +: NG];
  wire [NG-1:0] ver_on_s = pn_sync_q[2*NG +: NG];
  wire [NG-1:0] ver_off_s = pn_sync_q[3*NG +: NG];
  wire          link_s   = pn_sync_q[4*NG];
  wire          exp_s    = pn_sync_q[4*NG+1];
  wire          unused_s = pn_sync_q[4*NG+2];
  wire          pmode_s  = pn_sync_q[4*NG+3];

  // ----------------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------------
  // One counter serves the whole bundle: any change restarts it, so a new
  // position is accepted only after every switch stood still long enough.
  // The trade is a slower response while several switches move at once.
  logic [SW_W-1:0]             sw_prev_q, sw_stable_q;
  logic [smka_pkg::CNT_W-1:0]  deb_cnt_q;

  wire deb_done = (deb_cnt_q == smka_pkg::CNT_W'(DEBOUNCE_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_prev_q   <= '0;
      sw_stable_q <= '0;
      deb_cnt_q   <= '0;
    end else begin
      sw_prev_q <= sw_sync_q;
      if (sw_sync_q != sw_prev_q || sw_sync_q == sw_stable_q) deb_cnt_q <= '0;
      else if (deb_done) begin
        sw_stable_q <= sw_sync_q;
        deb_cnt_q   <= '0;
      end else deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  wire [NG-1:0]             sw_on   = sw_stable_q[0 +: NG];
  wire [NG-1:0]             sw_off  = sw_stable_q[NG +: NG];
  wire [smka_pkg::NCFG-1:0] cfg_sw  = sw_stable_q[2*NG +: smka_pkg::NCFG];
  wire                      ack_sw  = sw_stable_q[SW_W-1];

  // ----------------------------------------------------------------------
  // Flash prescaler
  // ----------------------------------------------------------------------
  logic [smka_pkg::CNT_W-1:0] pre_cnt_q;  // Counts one flash half period.
  logic                       flash_q;    // Rapid flash square wave.
  logic [2:0]                 phase_q;    // Half-period index for coded patterns.

  wire pre_tick = (pre_cnt_q == smka_pkg::CNT_W'(FLASH_HALF_CYC - 1));

  // All module trouble indications share this one rate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_q <= '0;
      flash_q   <= 1'b0;
      phase_q   <= 3'h0;
    end else if (pre_tick) begin
      pre_cnt_q <= '0;
      flash_q   <= ~flash_q;
      phase_q   <= phase_q + 3'h1;
    end else begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end

  // Two short flashes then a pause: tells mode trouble from link loss.
  wire dbl_flash = (phase_q == 3'h0) || (phase_q == 3'h2);

  // ----------------------------------------------------------------------
  // Trouble detection and piezo
  // ----------------------------------------------------------------------
  wire tr_link    = ~link_s;
  wire tr_exp     = ~unused_s & ~exp_s;
  wire tr_factory = (cfg_sw[5:0] == 6'h00);
  wire tr_mode    = (cfg_sw[smka_pkg::CFG_MODE_BIT] != pmode_s);
  wire [3:0] tr_vec = {tr_mode, tr_factory, tr_exp, tr_link};

  logic [3:0] tr_prev_q;  // Last trouble set, for new-trouble edges.
  logic       ack_prev_q; // Last acknowledge level.
  logic       piezo_q;    // Sounding request.

  wire ack_rise = ack_sw & ~ack_prev_q;
  wire new_tr   = |(tr_vec & ~tr_prev_q);

  // A new trouble in the same cycle as an acknowledge still sounds; the
  // sounder drops on its own once every trouble has cleared.
  wire piezo_d = ((piezo_q & ~ack_rise) | new_tr) & (|tr_vec);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tr_prev_q  <= 4'h0;
      ack_prev_q <= 1'b0;
      piezo_q    <= 1'b0;
    end else begin
      tr_prev_q  <= tr_vec;
      ack_prev_q <= ack_sw;
      piezo_q    <= piezo_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q;     // Bit 0: dedicated system, reported only.
  logic [31:0] type_lo_q;  // Group types 0-7.
  logic [31:0] type_hi_q;  // Group types 8-15.

  wire [63:0] types = {type_hi_q, type_lo_q};

  // ----------------------------------------------------------------------
  // Group outputs
  // ----------------------------------------------------------------------
  logic [NG-1:0] ctl_on_d, ctl_off_d, green_d, yellow_d, amber_d, manual_d;

  always_comb begin
    for (int g = 0; g < NG; g++) begin
      smka_pkg::smka_pos_e pos;
      logic [1:0]          c;
      logic [1:0]          l;
      pos = smka_pkg::POS_AUTO;
      if (sw_on[g] && !sw_off[g]) pos = smka_pkg::POS_ON;
      else if (sw_off[g] && !sw_on[g]) pos = smka_pkg::POS_OFF;
      c = ctl_map(types[4*g +: 4], pos, ev_on_s[g], ev_off_s[g]);
      l = led_map(types[4*g +: 4], ver_on_s[g], ver_off_s[g]);
      ctl_on_d[g]  = c[1];
      ctl_off_d[g] = c[0];
      manual_d[g]  = (pos != smka_pkg::POS_AUTO);
      green_d[g]   = tr_factory ? flash_q : l[1];
      yellow_d[g]  = tr_exp ? flash_q : l[0];
      // Amber sees troubles only; verification never reaches it.
      amber_d[g]   = tr_link ? flash_q : (tr_mode & dbl_flash);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_open_control_output    <= '0;
      off_closed_control_output <= '0;
      group_manual              <= '0;
      led_green                 <= '0;
      led_yellow                <= '0;
      led_amber                 <= '0;
    end else begin
      on_open_control_output    <= ctl_on_d;
      off_closed_control_output <= ctl_off_d;
      group_manual              <= manual_d;
      led_green                 <= green_d;
      led_yellow                <= yellow_d;
      led_amber                 <= amber_d;
    end
  end

  assign piezo = piezo_q;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic                        aw_full_q, w_full_q;  // Address or data held.
  logic [smka_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;

  wire aw_hs  = awvalid & awready;
  wire w_hs   = wvalid & wready;
  wire do_wr  = aw_full_q & w_full_q & ~bvalid;
  wire wa_ctl = (awaddr_q == smka_pkg::OFS_CTRL);
  wire wa_tlo = (awaddr_q == smka_pkg::OFS_TYPE_LO);
  wire wa_thi = (awaddr_q == smka_pkg::OFS_TYPE_HI);
  wire wa_ok  = wa_ctl | wa_tlo | wa_thi;

  // Write channel: address and data in either order, answer after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= smka_pkg::RESP_OKAY;
      ctrl_q    <= smka_pkg::RST_CTRL;
      type_lo_q <= smka_pkg::RST_TYPE;
      type_hi_q <= smka_pkg::RST_TYPE;
    end else begin
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready   <= 1'b0;
      end
      if (w_hs) begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready   <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wa_ok ? smka_pkg::RESP_OKAY : smka_pkg::RESP_SLVERR;
        if (wa_ctl) ctrl_q <= apply_strb(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
        if (wa_tlo) type_lo_q <= apply_strb(type_lo_q, wdata_q, wstrb_q);
        if (wa_thi) type_hi_q <= apply_strb(type_hi_q, wdata_q, wstrb_q);
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  wire [31:0] status_word = {manual_d, 11'h0, piezo_q, tr_mode, tr_factory, tr_exp, tr_link};
  wire        ra_ok = (araddr == smka_pkg::OFS_CTRL) || (araddr == smka_pkg::OFS_TYPE_LO) ||
                      (araddr == smka_pkg::OFS_TYPE_HI) || (araddr == smka_pkg::OFS_STATUS) ||
                      (araddr == smka_pkg::OFS_SWITCH);
  wire [31:0] rd_mux = (araddr == smka_pkg::OFS_CTRL)    ? ctrl_q :
                       (araddr == smka_pkg::OFS_TYPE_LO) ? type_lo_q :
                       (araddr == smka_pkg::OFS_TYPE_HI) ? type_hi_q :
                       (araddr == smka_pkg::OFS_STATUS)  ? status_word :
                       (araddr == smka_pkg::OFS_SWITCH)  ? {sw_off, sw_on} : 32'h0000_0000;

  // Read channel: data one edge after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= smka_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= ra_ok ? smka_pkg::RESP_OKAY : smka_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : smka_annunciator

// *** core/smka_pkg.sv ***
// Purpose: Shared constants for the smoke control switch annunciator.
// Assumes: 125 MHz aclk, synchronous active-low reset, AXI4-Lite register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
//
// Functional notes
// - Types 1-3: ON clears, OFF sets off/closed.
// - Types 4-6: ON sets, OFF clears on/open.
// - Types 7-9: ON/OFF drive both outputs oppositely.
// - Dedicated system: ON/OFF map identical, types 1-9.
// - Three indicators per switch: green, yellow, amber.
// - Types 1,4,7: green=!off verify, yellow=on verify.
// - Types 2,5,8: green=on verify, yellow=its inverse.
// - Types 3,6,9: green and yellow follow on verify.
// - Amber comes only from trouble logic.
// - Mode trouble has its own double flash; the others share the rapid flash.
// - Link lost: all amber flash rapidly, piezo sounds.
// - Expander missing, points in use: yellows flash, piezo.
// - Switches 1-6 all off: greens flash, piezo.
// - Switch 6 mode disagreeing with panel: mode trouble.
// - Local acknowledge silences the piezo.
package smka_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NGRP     = 16;  // Eight base groups plus eight expander groups.
  localparam int unsigned NCFG     = 8;   // Configuration switch positions.
  localparam int unsigned ADDR_W   = 6;   // Byte address width of the register window.
  localparam int unsigned CNT_W    = 24;  // Width of prescaler and debounce counters.

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned FLASH_HALF_MS  = 125;  // Half period of the rapid flash.
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned DEBOUNCE_MS    = 10;   // Least stable time of a switch.
  localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 6'h00;  // Bit 0 dedicated system.
  localparam logic [ADDR_W-1:0] OFS_TYPE_LO = 6'h04;  // Group types 0-7, four bits each.
  localparam logic [ADDR_W-1:0] OFS_TYPE_HI = 6'h08;  // Group types 8-15.
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 6'h0c;  // Troubles, piezo, manual groups.
  localparam logic [ADDR_W-1:0] OFS_SWITCH  = 6'h10;  // Debounced ON and OFF positions.

  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_TYPE = 32'h0000_0000;  // Type 0 means group unused.

  // Status field positions.
  localparam int unsigned ST_LINK    = 0;
  localparam int unsigned ST_EXP     = 1;
  localparam int unsigned ST_FACTORY = 2;
  localparam int unsigned ST_MODE    = 3;
  localparam int unsigned ST_PIEZO   = 4;
  localparam int unsigned ST_MANUAL  = 16;

  // Configuration switch position 6 selects smoke control mode when on.
  localparam int unsigned CFG_MODE_BIT = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Debounced switch position.
  typedef enum logic [1:0] {
    POS_AUTO,
    POS_ON,
    POS_OFF
  } smka_pos_e;

endpackage : smka_pkg
